/* rtl/chg_ctrl.sv */
`timescale 1ns/1ps
module chg_ctrl #(
  parameter logic [31:0] TIMER_TICKS = 32'h0100_0000,
  parameter int FILT_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic current_select_bit0,
  input wire logic current_select_bit1,
  input wire logic current_select_bit2,
  input wire chg_pkg::chg_ts_s pack_temp_sense,
  input wire chg_pkg::chg_supply_s supply,
  input wire chg_pkg::chg_die_s die,
  input wire logic vin_floor_active,
  input wire logic ilim_active,
  input wire logic bat_below_recharge,
  input wire logic term_current_reached,
  output logic buck_enable,
  output logic boost_enable,
  output logic charge_enable,
  output logic charge_half_current,
  output logic [12:0] vreg_target_mv,
  output logic [11:0] input_current_limit,
  output chg_pkg::chg_floor_e input_voltage_floor,
  output chg_pkg::chg_iscale_e input_current_scale,
  output logic aux_regulator_output,
  output logic input_valid_n_o,
  output logic input_valid_n_oe,
  output logic timer_fault
);
  // ****************************************
  // declarations
  // ****************************************
  logic [2:0] filt_code;
  chg_pkg::chg_cfg_s cfg_r;
  chg_pkg::chg_zone_e zone_r;
  chg_pkg::chg_zone_e zone_nxt;
  chg_pkg::chg_state_e state_r;
  chg_pkg::chg_state_e state_nxt;
  logic [1:0] ctrl_r;
  logic tsd_r;
  logic half_tick_r;
  logic [31:0] timer_cnt_r;
  logic [31:0] rd_nxt;
  logic rd_ok;
  logic en;
  logic dbl;
  logic supply_valid;
  logic chg_allowed;
  logic hold;
  logic slow;
  logic loop_active;
  logic term_ok;
  logic expire;
  logic timer_step;
  logic acc;

  // ****************************************
  // select pins
  // ****************************************
  chg_sel_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel_pins({current_select_bit2, current_select_bit1, current_select_bit0}),
    .code_r(filt_code)
  );

  // mode and limits from filtered code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '{chg_pkg::MODE_HIZ, chg_pkg::ILIM_NONE, chg_pkg::FLOOR_NONE};
    end else if (ce) begin
      cfg_r <= chg_pkg::decode_sel(filt_code);
    end
  end

  // ****************************************
  // pack temperature zones
  // ****************************************
  // zone from comparators
  always_comb begin
    if (pack_temp_sense.off) begin
      zone_nxt = chg_pkg::ZONE_NORMAL;
    end else if (pack_temp_sense.cold) begin
      zone_nxt = chg_pkg::ZONE_COLD;
    end else if (pack_temp_sense.hot) begin
      zone_nxt = chg_pkg::ZONE_HOT;
    end else if (pack_temp_sense.cool) begin
      zone_nxt = chg_pkg::ZONE_COOL;
    end else if (pack_temp_sense.warm) begin
      zone_nxt = chg_pkg::ZONE_WARM;
    end else begin
      zone_nxt = chg_pkg::ZONE_NORMAL;
    end
  end

  // zone register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_r <= chg_pkg::ZONE_NORMAL;
    end else if (ce) begin
      zone_r <= zone_nxt;
    end
  end

  // ****************************************
  // die thermal shutdown
  // ****************************************
  // trip latch with hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_r <= 1'b0;
    end else if (ce) begin
      if (die.above_trip) begin
        tsd_r <= 1'b1;
      end else if (die.below_trip_hyst) begin
        tsd_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // charge state machine
  // ****************************************
  // shared conditions
  always_comb begin
    en = ctrl_r[chg_pkg::CTRL_EN_BIT];
    dbl = ctrl_r[chg_pkg::CTRL_DBL_BIT];
    supply_valid = supply.above_uvlo & supply.above_sleep & ~supply.above_ovp;
    chg_allowed = (cfg_r.mode == chg_pkg::MODE_CHARGE) & supply_valid & en;
    hold = (zone_r == chg_pkg::ZONE_HOT) | (zone_r == chg_pkg::ZONE_COLD) | tsd_r;
    loop_active = vin_floor_active | ilim_active | die.at_thermal_reg_threshold;
    term_ok = term_current_reached & ~bat_below_recharge & ~hold & ~loop_active
      & (zone_r != chg_pkg::ZONE_WARM) & (zone_r != chg_pkg::ZONE_COOL);
    slow = (dbl & loop_active) | (zone_r == chg_pkg::ZONE_WARM)
      | (zone_r == chg_pkg::ZONE_COOL);
    // half rate as every other tick
    timer_step = ~hold & (~slow | half_tick_r);
    expire = timer_step & (timer_cnt_r == TIMER_TICKS - 32'h0000_0001);
  end

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      chg_pkg::ST_IDLE: begin
        // por, enable or hi-z exit starts cycle
        if (chg_allowed) begin
          state_nxt = chg_pkg::ST_CHARGE;
        end
      end
      chg_pkg::ST_CHARGE: begin
        if (!chg_allowed) begin
          state_nxt = chg_pkg::ST_IDLE;
        end else if (term_ok) begin
          state_nxt = chg_pkg::ST_DONE;
        end else if (expire) begin
          state_nxt = chg_pkg::ST_FAULT;
        end
      end
      chg_pkg::ST_DONE: begin
        if (!chg_allowed) begin
          state_nxt = chg_pkg::ST_IDLE;
        end else if (bat_below_recharge) begin
          state_nxt = chg_pkg::ST_CHARGE;
        end
      end
      chg_pkg::ST_FAULT: begin
        // clear on enable low or power loss
        if (!en || !supply.above_uvlo) begin
          state_nxt = chg_pkg::ST_IDLE;
        end
      end
      default: state_nxt = chg_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= chg_pkg::ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // safety timer
  // ****************************************
  // half rate tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_tick_r <= 1'b0;
    end else if (ce) begin
      half_tick_r <= ~half_tick_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_cnt_r <= '0;
    end else if (ce) begin
      if (state_nxt == chg_pkg::ST_CHARGE && state_r != chg_pkg::ST_CHARGE) begin
        timer_cnt_r <= '0;
      end else if (state_r == chg_pkg::ST_CHARGE && timer_step) begin
        timer_cnt_r <= timer_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_enable <= 1'b0;
      boost_enable <= 1'b0;
      charge_enable <= 1'b0;
      charge_half_current <= 1'b0;
      vreg_target_mv <= chg_pkg::VREG_NORMAL;
      input_current_limit <= chg_pkg::ILIM_NONE;
      input_voltage_floor <= chg_pkg::FLOOR_NONE;
      input_current_scale <= chg_pkg::ISCALE_FULL;
      aux_regulator_output <= 1'b0;
      input_valid_n_o <= 1'b0;
      input_valid_n_oe <= 1'b0;
      timer_fault <= 1'b0;
    end else if (ce) begin
      // hi-z and trip keep buck off
      buck_enable <= (cfg_r.mode == chg_pkg::MODE_CHARGE) & supply_valid & ~tsd_r;
      boost_enable <= (cfg_r.mode == chg_pkg::MODE_BOOST) & ~tsd_r;
      charge_enable <= (state_r == chg_pkg::ST_CHARGE) & ~hold;
      charge_half_current <= zone_r == chg_pkg::ZONE_COOL;
      vreg_target_mv <= (zone_r == chg_pkg::ZONE_WARM) ? chg_pkg::VREG_WARM
        : chg_pkg::VREG_NORMAL;
      input_current_limit <= cfg_r.ilim_ma;
      input_voltage_floor <= cfg_r.floor;
      input_current_scale <= die.above_thermal_reg_threshold_10 ? chg_pkg::ISCALE_ZERO
        : die.at_thermal_reg_threshold ? chg_pkg::ISCALE_REDUCED : chg_pkg::ISCALE_FULL;
      // aux on with supply unless tripped, off otherwise
      aux_regulator_output <= supply.above_uvlo & supply.above_sleep & ~tsd_r;
      input_valid_n_o <= 1'b0;
      input_valid_n_oe <= supply_valid & (cfg_r.mode != chg_pkg::MODE_BOOST);
      timer_fault <= state_r == chg_pkg::ST_FAULT;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // read mux
  always_comb begin
    rd_ok = 1'b1;
    rd_nxt = '0;
    case (paddr)
      chg_pkg::OFF_CTRL: rd_nxt = {30'h0, ctrl_r};
      chg_pkg::OFF_STATUS: rd_nxt = {20'h0_0000, supply_valid, tsd_r, cfg_r.mode,
        1'b0, zone_r, state_r};
      chg_pkg::OFF_TIMER: rd_nxt = timer_cnt_r;
      chg_pkg::OFF_CFG: rd_nxt = {18'h0_0000, cfg_r.floor, cfg_r.ilim_ma};
      default: rd_ok = 1'b0;
    endcase
    acc = psel & penable;
  end

  // one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~rd_ok;
      prdata <= (acc & ~pready & ~pwrite) ? rd_nxt : '0;
    end
  end

  // control register write at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= chg_pkg::CTRL_RESET;
    end else if (ce) begin
      if (acc && pready && pwrite && pstrb[0] && paddr == chg_pkg::OFF_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hiz_buck_off: assert property (
    ce && cfg_r.mode == chg_pkg::MODE_HIZ |=> !buck_enable
  ) else $error("buck enabled in high impedance mode");
  a_code_limits: assert property (
    ce && filt_code == 3'h1 |=> cfg_r.ilim_ma == chg_pkg::ILIM_500
      && cfg_r.floor == chg_pkg::FLOOR_4440
  ) else $error("code 001 limits wrong");
  a_boost_select: assert property (
    ce && filt_code == chg_pkg::SEL_BOOST ##1 ce |=> boost_enable == !$past(tsd_r)
      && input_current_limit == chg_pkg::ILIM_NONE
  ) else $error("boost code not applied");
  a_timer_counts: assert property (
    ce && state_r == chg_pkg::ST_CHARGE && state_nxt == chg_pkg::ST_CHARGE
      && timer_step |=> timer_cnt_r == $past(timer_cnt_r) + 32'h0000_0001
  ) else $error("safety timer did not advance");
  a_expire_fault: assert property (
    ce && state_r == chg_pkg::ST_CHARGE && chg_allowed && !term_ok && expire
      |=> state_r == chg_pkg::ST_FAULT
  ) else $error("expiry did not latch fault");
  a_fault_sticky: assert property (
    state_r == chg_pkg::ST_FAULT && en && supply.above_uvlo |=>
      state_r == chg_pkg::ST_FAULT
  ) else $error("fault cleared without toggle");
  a_half_rate: assert property (
    ce && state_r == chg_pkg::ST_CHARGE && zone_r == chg_pkg::ZONE_WARM
      && !half_tick_r && state_nxt == chg_pkg::ST_CHARGE |=> $stable(timer_cnt_r)
  ) else $error("timer full rate in warm zone");
  a_aux_uvlo_off: assert property (
    ce && (!supply.above_uvlo || tsd_r) |=> !aux_regulator_output
  ) else $error("aux regulator on below uvlo");
  a_hot_suspend: assert property (
    ce && zone_r == chg_pkg::ZONE_HOT |=> !charge_enable
  ) else $error("charging in hot zone");
  a_trip_hold: assert property (
    tsd_r && !die.below_trip_hyst |=> tsd_r
  ) else $error("thermal trip released early");
endmodule

/* rtl/chg_pkg.sv */
// Operation
// - all selects high: hi-z, buck off
// - low codes pick 100/500/1500mA limits
// - high codes pick 150/900/2500mA limits
// - code 011 selects boost, no limits
// - safety timer runs through charging
// - timer expiry latches fault, stops charge
// - fault cleared by enable toggle or power
// - double option: half rate in loops
// - half rate in warm or cool
// - aux regulator on with supply
// - aux off: uvlo, sleep, thermal trip
// - classify pack temperature zones
// - hot or cold suspends charge, timer
// - cool zone halves charge current
// - warm zone lowers target to 4.06V
// - sense off forces normal zone
// - die regulation reduces input current
// - thermal trip stops charge, buck, timer
// - resume only after trip hysteresis
// - input valid low inside supply window, except in boost
// - new cycle on recharge, por, enable
// - termination inhibited by loops, zones
package chg_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TIMER = 8'h08;
  localparam logic [7:0] OFF_CFG = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DBL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ****************************************
  // select codes and limits
  // ****************************************
  localparam logic [2:0] SEL_HIZ = 3'h7;
  localparam logic [2:0] SEL_BOOST = 3'h3;
  localparam logic [11:0] ILIM_NONE = 12'h000;
  localparam logic [11:0] ILIM_100 = 12'h064;
  localparam logic [11:0] ILIM_150 = 12'h096;
  localparam logic [11:0] ILIM_500 = 12'h1F4;
  localparam logic [11:0] ILIM_900 = 12'h384;
  localparam logic [11:0] ILIM_1500 = 12'h5DC;
  localparam logic [11:0] ILIM_2500 = 12'h9C4;
  localparam logic [12:0] VREG_NORMAL = 13'h1068;
  localparam logic [12:0] VREG_WARM = 13'h0FDC;
  typedef enum logic [1:0] {
    MODE_CHARGE = 2'h0, MODE_BOOST = 2'h1, MODE_HIZ = 2'h2
  } chg_mode_e;
  typedef enum logic [1:0] {
    FLOOR_NONE = 2'h0, FLOOR_4280 = 2'h1, FLOOR_4440 = 2'h2, FLOOR_EXT = 2'h3
  } chg_floor_e;
  typedef enum logic [2:0] {
    ZONE_NORMAL = 3'h0, ZONE_COLD = 3'h1, ZONE_COOL = 3'h2,
    ZONE_WARM = 3'h3, ZONE_HOT = 3'h4
  } chg_zone_e;
  typedef enum logic [1:0] {
    ISCALE_FULL = 2'h0, ISCALE_REDUCED = 2'h1, ISCALE_ZERO = 2'h2
  } chg_iscale_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_CHARGE = 4'b0010, ST_DONE = 4'b0100, ST_FAULT = 4'b1000
  } chg_state_e;
  typedef struct packed {
    chg_mode_e mode;
    logic [11:0] ilim_ma;
    chg_floor_e floor;
  } chg_cfg_s;
  // pack sense comparators
  typedef struct packed {
    logic cold;
    logic cool;
    logic warm;
    logic hot;
    logic off;
  } chg_ts_s;
  typedef struct packed {
    logic above_uvlo;
    logic above_sleep;
    logic above_ovp;
  } chg_supply_s;
  typedef struct packed {
    logic at_thermal_reg_threshold;
    logic above_thermal_reg_threshold_10;
    logic above_trip;
    logic below_trip_hyst;
  } chg_die_s;
  // select code to mode and limits
  function automatic chg_cfg_s decode_sel(input logic [2:0] sel);
    chg_cfg_s c;
    c = '{MODE_CHARGE, ILIM_NONE, FLOOR_NONE};
    case (sel)
      3'h0: c = '{MODE_CHARGE, ILIM_100, FLOOR_4280};
      3'h1: c = '{MODE_CHARGE, ILIM_500, FLOOR_4440};
      3'h2: c = '{MODE_CHARGE, ILIM_1500, FLOOR_EXT};
      SEL_BOOST: c = '{MODE_BOOST, ILIM_NONE, FLOOR_NONE};
      3'h4: c = '{MODE_CHARGE, ILIM_150, FLOOR_4280};
      3'h5: c = '{MODE_CHARGE, ILIM_900, FLOOR_4440};
      3'h6: c = '{MODE_CHARGE, ILIM_2500, FLOOR_EXT};
      default: c = '{MODE_HIZ, ILIM_NONE, FLOOR_NONE};
    endcase
    return c;
  endfunction
endpackage

/* rtl/chg_sel_filter.sv */
`timescale 1ns/1ps
module chg_sel_filter #(
  parameter int FILT_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [2:0] sel_pins,
  output logic [2:0] code_r
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] cand_r;
  logic [CW-1:0] cnt_r;

  // two flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= chg_pkg::SEL_HIZ;
      sync2_r <= chg_pkg::SEL_HIZ;
    end else if (ce) begin
      sync1_r <= sel_pins;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_r <= chg_pkg::SEL_HIZ;
      cnt_r <= '0;
      code_r <= chg_pkg::SEL_HIZ;
    end else if (ce) begin
      if (sync2_r != cand_r) begin
        cand_r <= sync2_r;
        cnt_r <= '0;
      end else if (cnt_r == CNT_LAST) begin
        code_r <= cand_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_filter_holds_code: assert property (
    ce && sync2_r != cand_r |=> $stable(code_r)
  ) else $error("select code changed while input unstable");
endmodule

/* tb/chg_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// host side: select pins and status pull-up
// ****************************************
module chg_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] code,
  input wire logic input_valid_n_o,
  input wire logic input_valid_n_oe,
  output logic current_select_bit0,
  output logic current_select_bit1,
  output logic current_select_bit2,
  output logic input_valid_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {current_select_bit2, current_select_bit1, current_select_bit0} <= 3'h7;
    end else begin
      {current_select_bit2, current_select_bit1, current_select_bit0} <= code;
    end
  end
  // pulled up when the device lets go
  assign input_valid_n = input_valid_n_oe ? input_valid_n_o : 1'b1;
endmodule

/* tb/test_charger_mode_timer_thermal_ctrl.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  tests_run++; \
  if ((gt) !== (ex)) begin \
    err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
  end \
end
module test_charger_mode_timer_thermal_ctrl;
  typedef struct {
    logic [2:0] sel;
    logic [11:0] ilim;
    chg_pkg::chg_floor_e fl;
    logic bst;
    logic bk;
  } chg_row_s;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1;
  logic [3:0] pstrb;
  logic [2:0] code;
  logic b0, b1, b2, vfl, ilm, rch, term;
  logic buck, bst, chg, half, aux, vo, voe, vn, tf;
  logic [12:0] vreg;
  logic [11:0] ilim;
  chg_pkg::chg_ts_s ts;
  chg_pkg::chg_supply_s sup;
  chg_pkg::chg_die_s dv;
  chg_pkg::chg_floor_e fl;
  chg_pkg::chg_iscale_e isc;
  int err_count, tests_run, cycles, n;
  chg_row_s rows [8] = '{
    '{3'h0, chg_pkg::ILIM_100, chg_pkg::FLOOR_4280, 1'b0, 1'b1},
    '{3'h1, chg_pkg::ILIM_500, chg_pkg::FLOOR_4440, 1'b0, 1'b1},
    '{3'h2, chg_pkg::ILIM_1500, chg_pkg::FLOOR_EXT, 1'b0, 1'b1},
    '{3'h3, chg_pkg::ILIM_NONE, chg_pkg::FLOOR_NONE, 1'b1, 1'b0},
    '{3'h4, chg_pkg::ILIM_150, chg_pkg::FLOOR_4280, 1'b0, 1'b1},
    '{3'h5, chg_pkg::ILIM_900, chg_pkg::FLOOR_4440, 1'b0, 1'b1},
    '{3'h6, chg_pkg::ILIM_2500, chg_pkg::FLOOR_EXT, 1'b0, 1'b1},
    '{3'h7, chg_pkg::ILIM_NONE, chg_pkg::FLOOR_NONE, 1'b0, 1'b0}};

  // ****************************************
  // design and host
  // ****************************************
  chg_ctrl #(.TIMER_TICKS(32'h0000_0040), .FILT_CYCLES(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_select_bit0(b0), .current_select_bit1(b1), .current_select_bit2(b2),
    .pack_temp_sense(ts), .supply(sup), .die(dv), .vin_floor_active(vfl),
    .ilim_active(ilm), .bat_below_recharge(rch), .term_current_reached(term),
    .buck_enable(buck), .boost_enable(bst), .charge_enable(chg),
    .charge_half_current(half), .vreg_target_mv(vreg), .input_current_limit(ilim),
    .input_voltage_floor(fl), .input_current_scale(isc), .aux_regulator_output(aux),
    .input_valid_n_o(vo), .input_valid_n_oe(voe), .timer_fault(tf)
  );
  chg_host_model i_host (
    .pclk(pclk), .presetn(presetn), .code(code), .input_valid_n_o(vo),
    .input_valid_n_oe(voe), .current_select_bit0(b0), .current_select_bit1(b1),
    .current_select_bit2(b2), .input_valid_n(vn)
  );

  // ****************************************
  // clock, timeout and tasks
  // ****************************************
  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic wait_n(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // one transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 64);
    if (w >= 64) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // restart charging and count cycles to the fault
  task automatic run_to_fault(input logic [31:0] cv);
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0000);
    apb(1'b1, chg_pkg::OFF_CTRL, cv);
    n = 0;
    while (tf !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {presetn, ce, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b010, 42'h0, 4'hf};
    {code, ts, sup, dv, vfl, ilm, rch, term} = {3'h7, 5'h00, 3'b110, 4'b0001, 4'h0};
    {err_count, tests_run, cycles} = '0;
    wait_n(16);
    presetn <= 1'b1;
    wait_n(2);
    `CHK("buck_rst", 1'b0, buck)
    `CHK("vreg_rst", chg_pkg::VREG_NORMAL, vreg)
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0000);
    foreach (rows[i]) begin
      code <= rows[i].sel;
      wait_n(20);
      `CHK("ilim", rows[i].ilim, ilim)
      `CHK("floor", rows[i].fl, fl)
      `CHK("boost", rows[i].bst, bst)
      `CHK("buck", rows[i].bk, buck)
      apb(1'b0, chg_pkg::OFF_CFG, 32'h0000_0000);
      `CHK("cfg", {18'h0_0000, rows[i].fl, rows[i].ilim}, rd)
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    done("modes");
    code <= 3'h1;
    wait_n(20);
    run_to_fault(32'h0000_0001);
    `CHK("timer_full", 1'b1, n >= 60 && n <= 75)
    `CHK("chg_fault", 1'b0, chg)
    code <= 3'h4;
    wait_n(20);
    `CHK("fault_held", 1'b1, tf)
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0000);
    wait_n(3);
    `CHK("fault_clear", 1'b0, tf)
    ts.warm <= 1'b1;
    term <= 1'b1;
    run_to_fault(32'h0000_0001);
    `CHK("timer_warm", 1'b1, n >= 120 && n <= 145)
    ts.warm <= 1'b0;
    ilm <= 1'b1;
    run_to_fault(32'h0000_0003);
    `CHK("timer_dbl", 1'b1, n >= 120 && n <= 145)
    ilm <= 1'b0;
    term <= 1'b0;
    done("timer");
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0000);
    ts.hot <= 1'b1;
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0001);
    wait_n(4);
    `CHK("hot_chg", 1'b0, chg)
    apb(1'b0, chg_pkg::OFF_TIMER, 32'h0000_0000);
    t1 = rd;
    wait_n(10);
    apb(1'b0, chg_pkg::OFF_TIMER, 32'h0000_0000);
    `CHK("hot_timer", t1, rd)
    ts <= 5'b10000;
    wait_n(4);
    `CHK("cold_chg", 1'b0, chg)
    ts <= 5'b01000;
    wait_n(4);
    `CHK("cool_half", 1'b1, half)
    `CHK("cool_chg", 1'b1, chg)
    ts <= 5'b00101;
    wait_n(4);
    `CHK("off_vreg", chg_pkg::VREG_NORMAL, vreg)
    ts <= 5'b00100;
    wait_n(4);
    `CHK("warm_vreg", chg_pkg::VREG_WARM, vreg)
    ts <= 5'b00000;
    done("zones");
    dv <= 4'b1001;
    wait_n(4);
    `CHK("thermal_reg_threshold", chg_pkg::ISCALE_REDUCED, isc)
    dv <= 4'b1101;
    wait_n(4);
    `CHK("thermal_reg_threshold_10", chg_pkg::ISCALE_ZERO, isc)
    dv <= 4'b1110;
    wait_n(4);
    `CHK("trip_buck", 1'b0, buck)
    `CHK("trip_chg", 1'b0, chg)
    `CHK("trip_aux", 1'b0, aux)
    dv <= 4'b0000;
    wait_n(4);
    `CHK("trip_hyst", 1'b0, buck)
    dv <= 4'b0001;
    wait_n(4);
    `CHK("trip_resume", 1'b1, buck)
    done("die");
    // termination with no loop and normal zone, then recharge
    term <= 1'b1;
    wait_n(4);
    apb(1'b0, chg_pkg::OFF_STATUS, 32'h0000_0000);
    t1 = {20'h0_0000, 1'b1, 1'b0, chg_pkg::MODE_CHARGE, 1'b0, chg_pkg::ZONE_NORMAL,
      chg_pkg::ST_DONE};
    `CHK("done_status", t1, rd)
    `CHK("done_chg", 1'b0, chg)
    rch <= 1'b1;
    wait_n(4);
    `CHK("rch_chg", 1'b1, chg)
    rch <= 1'b0;
    term <= 1'b0;
    done("recharge");
    sup <= 3'b100;
    wait_n(4);
    `CHK("sleep_aux", 1'b0, aux)
    `CHK("sleep_pg", 1'b1, vn)
    sup <= 3'b110;
    wait_n(4);
    `CHK("ok_aux", 1'b1, aux)
    `CHK("ok_pg", 1'b0, vn)
    sup <= 3'b111;
    wait_n(4);
    `CHK("ovp_pg", 1'b1, vn)
    sup <= 3'b010;
    wait_n(4);
    `CHK("uvlo_aux", 1'b0, aux)
    done("supply");
    // mid-run reset: control back to its reset value, charging restarts
    sup <= 3'b110;
    apb(1'b1, chg_pkg::OFF_CTRL, 32'h0000_0002);
    presetn <= 1'b0;
    wait_n(4);
    `CHK("rst_ilim", chg_pkg::ILIM_NONE, ilim)
    presetn <= 1'b1;
    apb(1'b0, chg_pkg::OFF_CTRL, 32'h0000_0000);
    `CHK("rst_ctrl", {30'h0, chg_pkg::CTRL_RESET}, rd)
    wait_n(16);
    `CHK("por_chg", 1'b1, chg)
    done("reset");
    end_of_test();
  end
endmodule
